//--- hw/isp_port.sv
// serial programming port with on-chip flash, page buffer and eeprom
// assumes sck, mosi and reset pin are asynchronous to ref_clk and that
// the programmer keeps each sck phase longer than two ref_clk cycles
`timescale 1ns/10ps

// What this block does
// - programming accepted only while reset pin low; serial in and out on sck
// - no program or erase before the enable instruction is accepted
// - each eeprom byte write first self-erases the location
// - chip erase sets all flash and eeprom locations to 0xff
// - incoming bits sampled on sck rising edge
// - outgoing bits shifted out on sck falling edge
// - when in sync, 0x53 echoes while third enable byte shifts in
// - flash written by pages; page buffer loaded per byte with 6-bit address
// - write-page with 7 high address bits commits the buffer to flash
// - eeprom written per byte with address and data, then waits
// - read instruction returns addressed content on serial output
// - reset pin high ends programming mode, normal operation resumes
// - flash page reads 0xff while written, then the written value
// - enable is 0xac, 0x53, two free bytes, after reset low
// - eeprom address reads 0xff while written, then the value
module isp_port
	import isp_pkg::*;
#(
	parameter int FLASH_CYC = FLASH_WAIT_CYC,
	parameter int EE_CYC    = EE_WAIT_CYC,
	parameter int ERASE_CYC = ERASE_WAIT_CYC
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic sck_pin,
	input  wire logic mosi_pin,
	input  wire logic reset_n_pin,
	output logic      miso_o,
	output logic      miso_oe,
	output logic      prog_mode,
	output logic      mem_busy,
	output logic      run_enable
);
	// ---------------------------------------------------------------
	// memories
	// ---------------------------------------------------------------
	logic [15:0] flash_mem [0:(1<<FLASH_AW)-1];
	logic [7:0]  ee_mem    [0:(1<<EE_AW)-1];
	logic [15:0] page_buf  [0:(1<<PAGE_AW)-1];
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic sck_s1_r, sck_s2_r, sck_s3_r;
	logic mosi_s1_r, mosi_s2_r;
	logic rstn_s1_r, rstn_s2_r;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sck_s1_r  <= 1'b0;
			sck_s2_r  <= 1'b0;
			sck_s3_r  <= 1'b0;
			mosi_s1_r <= 1'b0;
			mosi_s2_r <= 1'b0;
			rstn_s1_r <= 1'b1;
			rstn_s2_r <= 1'b1;
		end else begin
			sck_s1_r  <= sck_pin;
			sck_s2_r  <= sck_s1_r;
			sck_s3_r  <= sck_s2_r;
			mosi_s1_r <= mosi_pin;
			mosi_s2_r <= mosi_s1_r;
			rstn_s1_r <= reset_n_pin;
			rstn_s2_r <= rstn_s1_r;
		end
	end
	logic in_prog, sck_rise, sck_fall;
	assign in_prog  = ~rstn_s2_r;
	assign sck_rise = sck_s2_r & ~sck_s3_r;
	assign sck_fall = ~sck_s2_r & sck_s3_r;
	// ---------------------------------------------------------------
	// serial shifter and instruction capture
	// ---------------------------------------------------------------
	logic [7:0] rx_sr_r, b1_r, b2_r, b3_r, tx_sr_r;
	logic [2:0] bit_cnt_r;
	logic [1:0] byte_cnt_r;
	logic [7:0] rx_byte, rd_data;
	logic       byte_done, instr_done;
	eng_state_e st_r;
	assign rx_byte    = {rx_sr_r[6:0], mosi_s2_r};
	assign byte_done  = in_prog & sck_rise & (bit_cnt_r == 3'h7);
	assign instr_done = byte_done & (byte_cnt_r == 2'h3);
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !in_prog) begin
			rx_sr_r    <= 8'h00;
			bit_cnt_r  <= 3'h0;
			byte_cnt_r <= 2'h0;
			b1_r       <= 8'h00;
			b2_r       <= 8'h00;
			b3_r       <= 8'h00;
		end else if (sck_rise) begin
			rx_sr_r   <= rx_byte;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == 3'h7) begin
				byte_cnt_r <= byte_cnt_r + 2'h1;
				case (byte_cnt_r)
					2'h0:    b1_r <= rx_byte;
					2'h1:    b2_r <= rx_byte;
					2'h2:    b3_r <= rx_byte;
					default: ;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// read data for the fourth byte
	// ---------------------------------------------------------------
	function automatic logic [FPAGE_W-1:0] page_of(
		input logic [FLASH_AW-1:0] a
	);
		page_of = a[FLASH_AW-1:PAGE_AW];
	endfunction : page_of
	logic [FLASH_AW-1:0] rd_faddr;
	logic [EE_AW-1:0]    rd_eaddr;
	logic [15:0]         rd_word;
	logic                fl_busy;
	logic [FPAGE_W-1:0]  fl_page_r;
	logic [EE_AW-1:0]    ee_addr_r;
	assign rd_faddr = {b2_r[4:0], rx_byte};
	assign rd_eaddr = {b2_r[0], rx_byte};
	assign rd_word  = flash_mem[rd_faddr];
	assign fl_busy  = (st_r == ST_FL_WAIT) || (st_r == ST_FL_COPY);
	always_comb begin
		rd_data = NO_DATA;
		if ((b1_r & HI_SEL_MASK) == OP_READ_FLASH) begin
			if (fl_busy && page_of(rd_faddr) == fl_page_r)
				rd_data = ERASED_BYTE;
			else if (b1_r[HI_SEL_BIT])
				rd_data = rd_word[15:8];
			else
				rd_data = rd_word[7:0];
		end else if (b1_r == OP_READ_EE) begin
			// eeprom location holds 0xff until the write ends
			rd_data = ee_mem[rd_eaddr];
		end
	end
	// ---------------------------------------------------------------
	// serial output: echo of the previous byte, or read data
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !in_prog) begin
			tx_sr_r <= 8'h00;
			miso_o  <= 1'b0;
		end else if (byte_done) begin
			// third byte carries the echo of 0x53 when in sync
			if (byte_cnt_r == 2'h2)
				tx_sr_r <= rd_data;
			else
				tx_sr_r <= rx_byte;
		end else if (sck_fall) begin
			miso_o  <= tx_sr_r[7];
			tx_sr_r <= {tx_sr_r[6:0], 1'b0};
		end
	end

	// each byte but the fourth echoes the one before, so 0x53 shows during byte three
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			miso_oe    <= 1'b0;
			run_enable <= 1'b0;
		end else begin
			miso_oe    <= in_prog;
			run_enable <= ~in_prog;
		end
	end

	// ---------------------------------------------------------------
	// programming enable
	// ---------------------------------------------------------------
	logic cmd_ok;
	assign cmd_ok = instr_done & prog_mode & (st_r == ST_IDLE);
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !in_prog)
			prog_mode <= 1'b0;
		else if (instr_done && b1_r == OP_ENABLE_B1 &&
			b2_r == OP_ENABLE_B2)
			prog_mode <= 1'b1;
	end

	// ---------------------------------------------------------------
	// page buffer loading
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (cmd_ok && (b1_r & HI_SEL_MASK) == OP_LOAD_PAGE) begin
			if (b1_r[HI_SEL_BIT])
				page_buf[b3_r[PAGE_AW-1:0]][15:8] <= rx_byte;
			else
				page_buf[b3_r[PAGE_AW-1:0]][7:0] <= rx_byte;
		end
	end

	// ---------------------------------------------------------------
	// write engine
	// ---------------------------------------------------------------
	logic [CNT_W-1:0]    cnt_r;
	logic [FLASH_AW-1:0] idx_r;
	logic [7:0]          ee_data_r;
	logic                go_flash, go_ee, go_erase;
	assign go_flash = cmd_ok && b1_r == OP_WRITE_PAGE;
	assign go_ee    = cmd_ok && b1_r == OP_WRITE_EE;
	assign go_erase = cmd_ok && b1_r == OP_ENABLE_B1 &&
		b2_r[7:5] == OP_ERASE_B2;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_r      <= ST_IDLE;
			cnt_r     <= '0;
			idx_r     <= '0;
			fl_page_r <= '0;
			ee_addr_r <= '0;
			ee_data_r <= 8'h00;
		end else begin
			case (st_r)
				ST_IDLE: begin
					idx_r <= '0;
					if (go_flash) begin
						st_r      <= ST_FL_WAIT;
						cnt_r     <= CNT_W'(FLASH_CYC - 1);
						fl_page_r <= {b2_r[4:0], b3_r[7:6]};
					end else if (go_ee) begin
						st_r      <= ST_EE_WAIT;
						cnt_r     <= CNT_W'(EE_CYC - 1);
						ee_addr_r <= {b2_r[0], b3_r};
						ee_data_r <= rx_byte;
					end else if (go_erase) begin
						st_r  <= ST_ER_SWEEP;
						cnt_r <= CNT_W'(ERASE_CYC - 1);
					end
				end
				ST_FL_WAIT: begin
					cnt_r <= cnt_r - 1'b1;
					if (cnt_r == '0)
						st_r <= ST_FL_COPY;
				end
				ST_FL_COPY: begin
					idx_r <= idx_r + 1'b1;
					if (idx_r[PAGE_AW-1:0] == '1)
						st_r <= ST_IDLE;
				end
				ST_EE_WAIT: begin
					cnt_r <= cnt_r - 1'b1;
					if (cnt_r == '0)
						st_r <= ST_IDLE;
				end
				ST_ER_SWEEP: begin
					// erase time runs down while the arrays are swept
					idx_r <= idx_r + 1'b1;
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					if (idx_r == '1)
						st_r <= ST_ER_WAIT;
				end
				ST_ER_WAIT: begin
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else
						st_r <= ST_IDLE;
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	assign mem_busy = (st_r != ST_IDLE);
	// ---------------------------------------------------------------
	// array writes; flash and eeprom commit after the wait, erase sweeps before it, so only polls during the erase sweep can see old data
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (st_r == ST_FL_COPY)
			flash_mem[{fl_page_r, idx_r[PAGE_AW-1:0]}] <=
				page_buf[idx_r[PAGE_AW-1:0]];
		if (st_r == ST_ER_SWEEP) begin
			flash_mem[idx_r] <= ERASED_WORD;
			if (idx_r[FLASH_AW-1:EE_AW] == '0)
				ee_mem[idx_r[EE_AW-1:0]] <= ERASED_BYTE;
		end
		if (go_ee)
			ee_mem[{b2_r[0], b3_r}] <= ERASED_BYTE;
		else if (st_r == ST_EE_WAIT && cnt_r == '0)
			ee_mem[ee_addr_r] <= ee_data_r;
	end
endmodule : isp_port

//--- shared/isp_pkg.sv
// constants for the serial programming port: opcodes, geometry, timing
// assumes a 100 MHz core clock; all counts derive from it
package isp_pkg;
	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int FLASH_WAIT_US  = 4500;  // flash_page_wait_delay, 4.5 ms
	localparam int EE_WAIT_US     = 9000;  // eeprom_byte_wait_delay, 9.0 ms
	localparam int ERASE_WAIT_US  = 9000;  // chip erase, 9.0 ms
	localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * CLK_MHZ;
	localparam int EE_WAIT_CYC    = EE_WAIT_US * CLK_MHZ;
	localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
	localparam int CNT_W          = 20;
	// ---------------------------------------------------------------
	// memory geometry
	// ---------------------------------------------------------------
	localparam int FLASH_AW = 13;  // word address, 8k words
	localparam int PAGE_AW  = 6;   // word within page
	localparam int FPAGE_W  = 7;   // page number
	localparam int EE_AW    = 9;   // 512 bytes
	localparam logic [7:0]  ERASED_BYTE = 8'hff;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	// ---------------------------------------------------------------
	// instruction bytes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_ENABLE_B1   = 8'hac;
	localparam logic [7:0] OP_ENABLE_B2   = 8'h53;
	localparam logic [2:0] OP_ERASE_B2    = 3'h4;   // byte 2 bits 7:5
	localparam logic [7:0] OP_READ_FLASH  = 8'h20;  // bit 3 selects high
	localparam logic [7:0] OP_LOAD_PAGE   = 8'h40;  // bit 3 selects high
	localparam logic [7:0] OP_WRITE_PAGE  = 8'h4c;
	localparam logic [7:0] OP_READ_EE     = 8'ha0;
	localparam logic [7:0] OP_WRITE_EE    = 8'hc0;
	localparam logic [7:0] HI_SEL_MASK    = 8'hf7;
	localparam int         HI_SEL_BIT     = 3;
	localparam logic [7:0] NO_DATA        = 8'h00;
	// ---------------------------------------------------------------
	// write engine states, gray along idle-wait-copy and eeprom paths
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_FL_WAIT  = 3'h1,
		ST_FL_COPY  = 3'h3,
		ST_EE_WAIT  = 3'h2,
		ST_ER_SWEEP = 3'h6,
		ST_ER_WAIT  = 3'h7
	} eng_state_e;
endpackage : isp_pkg

//--- dv/isp_port_asserts.sv
// checker: port-level timing of the serial programming port
// assumes binding onto isp_port with its wait-count parameters
`timescale 1ns/10ps
module isp_port_asserts #(
	parameter int FLASH_CYC = 100,
	parameter int EE_CYC    = 100,
	parameter int ERASE_CYC = 100
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic sck_pin,
	input wire logic mosi_pin,
	input wire logic reset_n_pin,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic prog_mode,
	input wire logic mem_busy,
	input wire logic run_enable
);
	// ----
	// busy length counter
	// ----
	localparam int MIN_BUSY = (EE_CYC < FLASH_CYC) ? EE_CYC : FLASH_CYC;
	logic [31:0] busy_cnt_r;
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !mem_busy)
			busy_cnt_r <= '0;
		else
			busy_cnt_r <= busy_cnt_r + 32'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// ----
	// properties
	// ----
	a_oe_in_session: assert property (!reset_n_pin [*6] |-> miso_oe)
		else $error("miso not driven in session");
	a_idle_no_mode: assert property (reset_n_pin [*6] |->
		!miso_oe && !prog_mode)
		else $error("session state outside reset");
	a_run_off_low: assert property (!reset_n_pin [*6] |-> !run_enable)
		else $error("running while reset pin low");
	a_miso_on_fall: assert property ($changed(miso_o) |->
		!$past(sck_pin, 2) || $past(reset_n_pin, 2))
		else $error("miso moved outside sck low");
	a_miso_steady_high: assert property (
		(sck_pin && !reset_n_pin) [*6] |-> $stable(miso_o))
		else $error("miso moved while sck high");
	a_mode_on_rise: assert property ($rose(prog_mode) |->
		$past(sck_pin, 2) && !reset_n_pin)
		else $error("mode set off an sck rise");
	a_mode_drop_pin: assert property ($fell(prog_mode) |->
		$past(reset_n_pin, 2))
		else $error("mode dropped with pin low");
	a_busy_needs_mode: assert property ($rose(mem_busy) |->
		$past(prog_mode) && $past(sck_pin, 2))
		else $error("write started without enable");
	a_busy_min_len: assert property ($fell(mem_busy) |->
		$past(busy_cnt_r) >= MIN_BUSY - 1)
		else $error("write finished too early");
endmodule : isp_port_asserts

bind isp_port isp_port_asserts #(.FLASH_CYC(FLASH_CYC), .EE_CYC(EE_CYC),
	.ERASE_CYC(ERASE_CYC)) chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.sck_pin(sck_pin), .mosi_pin(mosi_pin), .reset_n_pin(reset_n_pin),
	.miso_o(miso_o), .miso_oe(miso_oe), .prog_mode(prog_mode),
	.mem_busy(mem_busy), .run_enable(run_enable));

//--- dv/isp_programmer.sv
// model of the external programmer: sck, mosi and the reset pin
// assumes a 100 MHz ref_clk; sck stands low between instructions
`timescale 1ns/10ps
module isp_programmer
	import isp_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic miso,
	output logic      sck,
	output logic      mosi,
	output logic      rst_n
);
	localparam int HALF = 8;  // 80 ns phases, well over 3 cycles
	initial begin
		sck   = 1'b0;  // power up with clock and reset low
		mosi  = 1'b0;
		rst_n = 1'b0;
	end
	task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
		for (int i = 31; i >= 0; i--) begin
			mosi <= cmd[i];
			repeat (HALF) @(posedge ref_clk);
			resp[i] = miso;
			sck <= 1'b1;
			repeat (HALF) @(posedge ref_clk);
			sck <= 1'b0;
		end
	endtask : xfer
	task automatic set_reset(input logic v);
		rst_n <= v;
		@(posedge ref_clk);
	endtask : set_reset
	task automatic enable(output logic [7:0] echo);
		logic [31:0] r;
		xfer({OP_ENABLE_B1, OP_ENABLE_B2, 16'h0}, r);  // all four bytes
		echo = r[15:8];
		if (echo !== OP_ENABLE_B2) begin  // out of sync: pulse and retry
			rst_n <= 1'b1;
			repeat (4) @(posedge ref_clk);
			rst_n <= 1'b0;
			repeat (8) @(posedge ref_clk);
			xfer({OP_ENABLE_B1, OP_ENABLE_B2, 16'h0}, r);
			echo = r[15:8];
		end
	endtask : enable
	task automatic load_word(input logic [12:0] a, input logic [15:0] d);
		logic [31:0] r;
		xfer({OP_LOAD_PAGE, 8'h00, 2'b00, a[5:0], d[7:0]}, r);  // low first
		xfer({OP_LOAD_PAGE | 8'h08, 8'h00, 2'b00, a[5:0], d[15:8]}, r);
	endtask : load_word
endmodule : isp_programmer

//--- dv/isp_port_tb.sv
// self-checking bench for the serial programming port
// assumes the programmer model and the bound checker alongside
`timescale 1ns/10ps
module isp_port_tb;
	import isp_pkg::*;
	localparam int FW = 2000;  // short waits keep reads inside busy
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        sck, mosi, rst_n, miso_o, miso_oe;
	logic        prog_mode, mem_busy, run_enable;
	int          bad_count = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [31:0] r;
	logic [12:0] wa;
	logic [8:0]  ea;
	logic [15:0] wd;
	logic [7:0]  ed;
	always #5 ref_clk = ~ref_clk;
	isp_port #(.FLASH_CYC(FW), .EE_CYC(FW), .ERASE_CYC(100)) dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .sck_pin(sck), .mosi_pin(mosi),
		.reset_n_pin(rst_n), .miso_o(miso_o), .miso_oe(miso_oe),
		.prog_mode(prog_mode), .mem_busy(mem_busy), .run_enable(run_enable));
	// released miso shows the inverse, so stale data cannot pass
	isp_programmer prog (.ref_clk(ref_clk), .miso(miso_oe ? miso_o : ~miso_o),
		.sck(sck), .mosi(mosi), .rst_n(rst_n));
	// ----
	// checks and helpers
	// ----
	task automatic stop_test();
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task automatic chk_byte(input string n, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk_byte
	task automatic chk_bit(input string n, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %b got %b", n, e, g);
		end
	endtask : chk_bit
	function automatic logic [31:0] f_ee(input logic [7:0] op,
		input logic [8:0] a, input logic [7:0] d);
		return {op, 7'h0, a, d};
	endfunction : f_ee
	task automatic rd_fl(input logic [12:0] a, input logic h,
		input logic [7:0] e);
		prog.xfer({OP_READ_FLASH | {4'h0, h, 3'h0}, 3'h0, a, 8'h00}, r);
		chk_byte("flash read", e, r[7:0]);
	endtask : rd_fl
	task automatic rd_ee(input logic [8:0] a, input logic [7:0] e);
		prog.xfer(f_ee(OP_READ_EE, a, 8'h00), r);
		chk_byte("eeprom read", e, r[7:0]);
	endtask : rd_ee
	task automatic wait_idle();
		for (int n = 0; n < 20000 && mem_busy !== 1'b0; n++)
			@(posedge ref_clk);
		chk_bit("mem_busy", 1'b0, mem_busy);  // polled, never 0xff data
	endtask : wait_idle
	// hang guard, roughly twice the expected run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 80000) begin
			bad_count++;
			stop_test();
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(32'h2ad7));
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (200) @(posedge ref_clk);  // shortened power-up wait
		chk_bit("run_enable", 1'b0, run_enable);
		chk_bit("miso_oe", 1'b1, miso_oe);
		prog.xfer(f_ee(OP_WRITE_EE, 9'h005, 8'h3c), r);
		repeat (4) @(posedge ref_clk);
		chk_bit("mem_busy", 1'b0, mem_busy);  // refused before enable
		prog.enable(ed);
		chk_byte("echo", OP_ENABLE_B2, ed);
		chk_bit("prog_mode", 1'b1, prog_mode);
		prog.xfer({OP_ENABLE_B1, OP_ERASE_B2, 5'h0, 16'h0}, r);
		wait_idle();
		rd_fl(13'h1abc, 1'b1, ERASED_BYTE);
		rd_ee(9'h005, ERASED_BYTE);
		for (int k = 0; k < 3; k++) begin
			wa = (k == 0) ? 13'h1fff : 13'($urandom);
			ea = (k == 1) ? ea : 9'($urandom);
			wd = (k == 0) ? 16'h0000 : 16'($urandom_range(16'hfefe));
			ed = (k == 0) ? 8'h00 : 8'($urandom_range(8'hfe));
			prog.xfer(f_ee(OP_WRITE_EE, ea, ed), r);
			rd_ee(ea, ERASED_BYTE);
			wait_idle();
			rd_ee(ea, ed);  // overwrite needs no erase
			prog.load_word(wa, wd);
			prog.xfer({OP_WRITE_PAGE, 3'h0, wa[12:6], 6'h0, 8'h00}, r);
			rd_fl({wa[12:6], ~wa[5:0]}, 1'b0, ERASED_BYTE);
			wait_idle();
			rd_fl(wa, 1'b0, wd[7:0]);
			rd_fl(wa, 1'b1, wd[15:8]);
		end
		prog.set_reset(1'b1);
		repeat (8) @(posedge ref_clk);
		chk_bit("prog_mode", 1'b0, prog_mode);
		chk_bit("run_enable", 1'b1, run_enable);
		chk_bit("miso_oe", 1'b0, miso_oe);
		stop_test();
	end
endmodule : isp_port_tb
